/* File: mfr_consts.svh */
`ifndef MFR_CONSTS_SVH
`define MFR_CONSTS_SVH
// ---------------------------------------------
// opcodes
// ---------------------------------------------
`define MFR_OP_DO 8'h3B
`define MFR_OP_QO 8'h6B
`define MFR_OP_DIO 8'hBB
`define MFR_OP_QIO 8'hEB
`define MFR_OP_WIO 8'hE7
`define MFR_OP_WRP 8'h77
// ---------------------------------------------
// phase lengths in bits
// ---------------------------------------------
`define MFR_OPC_BITS 6'h08
`define MFR_ADDR_BITS 6'h18
`define MFR_MODE_BITS 6'h08
`define MFR_BYTE_BITS 4'h8
// ---------------------------------------------
// dummy clocks
// ---------------------------------------------
`define MFR_DUM_OUT 4'h8
`define MFR_DUM_QIO 4'h4
`define MFR_DUM_WIO 4'h2
`define MFR_DUM_DIO 4'h0
// ---------------------------------------------
// fields and reset values
// ---------------------------------------------
`define MFR_CONT_KEY 2'b10
`define MFR_WRAP_RST 3'b001
`define MFR_WRAP_MIN 8'h08
`define MFR_SY_RST 6'h10
`define MFR_SCLK_BIT 5
`define MFR_CS_BIT 4
`endif

/* File: mfr_pkg.sv */
package mfr_pkg;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_OPC = 7'h02,
    S_ADR = 7'h04,
    S_MOD = 7'h08,
    S_DUM = 7'h10,
    S_DAT = 7'h20,
    S_SKIP = 7'h40
  } mfr_state_t;
  typedef enum logic [2:0] {
    C_DO = 3'h0,
    C_QO = 3'h1,
    C_DIO = 3'h2,
    C_QIO = 3'h3,
    C_WIO = 3'h4,
    C_WRP = 3'h5
  } mfr_cmd_t;
  typedef struct packed {
    logic [5:0] sy1;
    logic [5:0] sy2;
    logic sclk_d;
    mfr_state_t st;
    mfr_cmd_t cmd;
    logic [5:0] cnt;
    logic [23:0] sh;
    logic [3:0] dcnt;
    logic [23:0] addr;
    logic [7:0] obyte;
    logic [3:0] ocnt;
    logic cont;
    logic [2:0] wrap;
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } mfr_regs_t;
endpackage : mfr_pkg

/* File: mfr_multi_io_fast_read.sv */
// Functional notes
// (RULE1) 3Bh: address on one line, data two bits per clock on IO1/IO0.
// (RULE2) dual output read: eight dummy clocks, inputs ignored meanwhile.
// (RULE3) host releases driven IO lines before first data-out falling edge.
// (RULE4) 6Bh: data four bits per clock, refused unless quad_enable set.
// (RULE5) quad output read: eight dummy clocks after the address.
// (RULE6) BBh: address and data two bits per clock on IO1/IO0.
// (RULE7) eight mode bits follow address; upper nibble used, lower ignored.
// (RULE8) mode bits 5:4 equal 10: next frame skips opcode, starts at address.
// (RULE9) any other mode value: next frame needs full opcode.
// (RULE10) host leaves dual continuous mode with sixteen clocks of ones.
// (RULE11) host leaves quad continuous mode with eight clocks of ones.
// (RULE12) EBh in SPI: four lines for address and data, four dummies.
// (RULE13) EBh and E7h accepted only while quad_enable is set.
// (RULE14) wrap enabled: quad reads wrap inside aligned 8..64-byte section; only EBh and E7h wrap here, 6Bh does not.
// (RULE15) wrap bit 4 enables wrapping, bits 6:5 pick section length.
// (RULE16) quad command mode: EBh dummies 2/4/6/8 by field, default 2.
// (RULE17) quad command mode: mode bit clocks count as dummy clocks.
// (RULE18) opcode skipping also works for EBh in quad command mode.
// (RULE19) quad command mode: EBh never wraps.
// (RULE20) host gives even address for E7h.
// (RULE21) E7h: two dummy clocks after address and mode bits.
// (RULE22) 77h: opcode, 24 dummy bits, eight wrap bits; 7 and 3:0 unused.
// (RULE23) wrap codes 00..11 give 8..64 bytes; bit 4 resets to 1.
// (RULE24) each clock carries highest remaining bits, top line highest bit.
`timescale 1ns/1ps
`include "mfr_consts.svh"
module mfr_multi_io_fast_read (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // flash pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // configuration
  input wire logic quad_enable,
  input wire logic quad_command_mode,
  input wire logic [1:0] dummy_count_field,
  // memory array
  output logic [23:0] mem_addr,
  input wire logic [7:0] mem_data,
  // status
  output logic cont_mode_active,
  output logic [2:0] wrap_setting_bits
);
  mfr_pkg::mfr_regs_t s_reg;
  mfr_pkg::mfr_regs_t s_next;
  logic rise;
  logic fall;
  logic cs_hi;
  logic [3:0] pin;
  logic wrap_on;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [2:0] addr_lanes(
    input mfr_pkg::mfr_cmd_t c, input logic q);
    logic [2:0] r;
    r = 3'h1;
    if (q || c == mfr_pkg::C_QIO || c == mfr_pkg::C_WIO)
      r = 3'h4;
    else if (c == mfr_pkg::C_DIO)
      r = 3'h2;
    return r;
  endfunction : addr_lanes

  function automatic logic [2:0] data_lanes(
    input mfr_pkg::mfr_cmd_t c);
    logic [2:0] r;
    r = 3'h4;
    if (c == mfr_pkg::C_DO || c == mfr_pkg::C_DIO)
      r = 3'h2;
    return r;
  endfunction : data_lanes

  // most significant bits arrive first, top line carries top bit
  function automatic logic [23:0] shift_in(
    input logic [23:0] sh, input logic [3:0] io,
    input logic [2:0] ln);
    logic [23:0] r;
    case (ln)
      3'h1: r = {sh[22:0], io[0]}; // [RULE24]
      3'h2: r = {sh[21:0], io[1:0]}; // [RULE24]
      default: r = {sh[19:0], io}; // [RULE24]
    endcase
    return r;
  endfunction : shift_in

  function automatic logic [3:0] dummies(
    input mfr_pkg::mfr_cmd_t c, input logic q,
    input logic [1:0] f);
    logic [3:0] r;
    case (c)
      mfr_pkg::C_QIO: begin
        // mode clocks already cover the first two dummies
        if (q)
          r = {1'b0, f, 1'b0}; // [RULE16] [RULE17]
        else
          r = `MFR_DUM_QIO; // [RULE12]
      end
      mfr_pkg::C_WIO: r = `MFR_DUM_WIO; // [RULE21]
      mfr_pkg::C_DIO: r = `MFR_DUM_DIO;
      default: r = `MFR_DUM_OUT; // [RULE2] [RULE5]
    endcase
    return r;
  endfunction : dummies

  function automatic logic [23:0] next_addr(
    input logic [23:0] a, input logic w,
    input logic [1:0] len);
    logic [7:0] m;
    logic [23:0] inc;
    m = 8'((`MFR_WRAP_MIN << len) - 8'h01);
    inc = a + 24'h000001;
    if (w)
      inc = {a[23:8], (a[7:0] & ~m) | (inc[7:0] & m)}; // [RULE14]
    return inc;
  endfunction : next_addr

  function automatic logic has_mode(
    input mfr_pkg::mfr_cmd_t c);
    return c == mfr_pkg::C_DIO || c == mfr_pkg::C_QIO ||
           c == mfr_pkg::C_WIO || c == mfr_pkg::C_WRP;
  endfunction : has_mode

  // ---------------------------------------------
  // pin sampling
  // ---------------------------------------------
  assign pin = s_reg.sy2[3:0];
  assign cs_hi = s_reg.sy2[`MFR_CS_BIT];
  assign rise = s_reg.sy2[`MFR_SCLK_BIT] & ~s_reg.sclk_d;
  assign fall = ~s_reg.sy2[`MFR_SCLK_BIT] & s_reg.sclk_d;
  // quad command mode never wraps, wrap bit 4 low enables
  assign wrap_on = ~s_reg.wrap[0] & ~quad_command_mode &
                   (s_reg.cmd == mfr_pkg::C_QIO ||
                    s_reg.cmd == mfr_pkg::C_WIO); // [RULE15] [RULE19]

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    logic [2:0] ln;
    logic [7:0] w;
    ln = addr_lanes(s_reg.cmd, quad_command_mode);
    w = s_reg.obyte;
    s_next = s_reg;
    s_next.sy1 = {sclk, cs_n, io_in};
    s_next.sy2 = s_reg.sy1;
    s_next.sclk_d = s_reg.sy2[`MFR_SCLK_BIT];
    if (cs_hi) begin
      s_next.st = mfr_pkg::S_IDLE;
      s_next.io_oe = 4'h0;
    end else begin
      case (s_reg.st)
        mfr_pkg::S_IDLE: begin
          s_next.cnt = 6'h00;
          s_next.sh = 24'h000000;
          s_next.ocnt = 4'h0;
          if (s_reg.cont)
            s_next.st = mfr_pkg::S_ADR; // [RULE8] [RULE18]
          else
            s_next.st = mfr_pkg::S_OPC; // [RULE9]
        end
        mfr_pkg::S_OPC: begin
          if (rise) begin
            ln = quad_command_mode ? 3'h4 : 3'h1;
            s_next.sh = shift_in(s_reg.sh, pin, ln);
            s_next.cnt = s_reg.cnt + {3'h0, ln};
            if (s_next.cnt == `MFR_OPC_BITS) begin
              s_next.cnt = 6'h00;
              s_next.st = mfr_pkg::S_ADR;
              case (s_next.sh[7:0])
                `MFR_OP_DO: s_next.cmd = mfr_pkg::C_DO; // [RULE1]
                `MFR_OP_QO: s_next.cmd = mfr_pkg::C_QO;
                `MFR_OP_DIO: s_next.cmd = mfr_pkg::C_DIO; // [RULE6]
                `MFR_OP_QIO: s_next.cmd = mfr_pkg::C_QIO;
                `MFR_OP_WIO: s_next.cmd = mfr_pkg::C_WIO;
                `MFR_OP_WRP: s_next.cmd = mfr_pkg::C_WRP; // [RULE22]
                default: s_next.st = mfr_pkg::S_SKIP;
              endcase
              // only EBh is served in quad command mode
              if (quad_command_mode &&
                  s_next.sh[7:0] != `MFR_OP_QIO)
                s_next.st = mfr_pkg::S_SKIP;
              if (!quad_enable &&
                  (s_next.cmd == mfr_pkg::C_QO ||
                   s_next.cmd == mfr_pkg::C_QIO ||
                   s_next.cmd == mfr_pkg::C_WIO))
                s_next.st = mfr_pkg::S_SKIP; // [RULE4] [RULE13]
              s_next.sh = 24'h000000;
            end
          end
        end
        mfr_pkg::S_ADR: begin
          if (rise) begin
            s_next.sh = shift_in(s_reg.sh, pin, ln);
            s_next.cnt = s_reg.cnt + {3'h0, ln};
            if (s_next.cnt == `MFR_ADDR_BITS) begin
              s_next.cnt = 6'h00;
              s_next.addr = s_next.sh;
              s_next.dcnt = dummies(s_reg.cmd, quad_command_mode,
                                    dummy_count_field);
              if (has_mode(s_reg.cmd))
                s_next.st = mfr_pkg::S_MOD; // [RULE7]
              else
                s_next.st = mfr_pkg::S_DUM;
            end
          end
        end
        mfr_pkg::S_MOD: begin
          if (rise) begin
            s_next.sh = shift_in(s_reg.sh, pin, ln);
            s_next.cnt = s_reg.cnt + {3'h0, ln};
            if (s_next.cnt == `MFR_MODE_BITS) begin
              s_next.cnt = 6'h00;
              if (s_reg.cmd == mfr_pkg::C_WRP) begin
                s_next.wrap = s_next.sh[6:4]; // [RULE15] [RULE22]
                s_next.st = mfr_pkg::S_SKIP;
              end else begin
                // lower nibble ignored
                s_next.cont = s_next.sh[5:4] ==
                              `MFR_CONT_KEY; // [RULE8] [RULE9]
                if (s_reg.dcnt == 4'h0)
                  s_next.st = mfr_pkg::S_DAT; // [RULE17]
                else
                  s_next.st = mfr_pkg::S_DUM;
              end
            end
          end
        end
        mfr_pkg::S_DUM: begin
          // pin values during dummies are not looked at
          if (rise) begin
            s_next.dcnt = s_reg.dcnt - 4'h1; // [RULE2]
            if (s_reg.dcnt == 4'h1)
              s_next.st = mfr_pkg::S_DAT;
          end
        end
        mfr_pkg::S_DAT: begin
          if (fall) begin
            ln = data_lanes(s_reg.cmd);
            if (s_reg.ocnt == 4'h0) begin
              w = mem_data;
              s_next.ocnt = `MFR_BYTE_BITS;
              s_next.addr = next_addr(s_reg.addr, wrap_on,
                                      s_reg.wrap[2:1]);
            end
            if (ln == 3'h2) begin
              s_next.io_out = {2'b00, w[7:6]}; // [RULE1] [RULE24]
              s_next.io_oe = 4'h3; // [RULE6]
              s_next.obyte = {w[5:0], 2'b00};
            end else begin
              s_next.io_out = w[7:4]; // [RULE4] [RULE24]
              s_next.io_oe = 4'hF; // [RULE12]
              s_next.obyte = {w[3:0], 4'h0};
            end
            s_next.ocnt = s_next.ocnt - {1'b0, ln};
          end
        end
        mfr_pkg::S_SKIP: s_next.io_oe = 4'h0;
        default: s_next.st = mfr_pkg::S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // state register
  // ---------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.sy1 <= `MFR_SY_RST;
      s_reg.sy2 <= `MFR_SY_RST;
      s_reg.st <= mfr_pkg::S_IDLE;
      s_reg.cmd <= mfr_pkg::C_DO;
      s_reg.wrap <= `MFR_WRAP_RST; // [RULE23]
    end else begin
      s_reg <= s_next;
    end
  end

  assign io_out = s_reg.io_out;
  assign io_oe = s_reg.io_oe;
  assign mem_addr = s_reg.addr;
  assign cont_mode_active = s_reg.cont;
  assign wrap_setting_bits = s_reg.wrap;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_mode_done;
    s_reg.st == mfr_pkg::S_MOD && s_next.st != mfr_pkg::S_MOD &&
    s_reg.cmd != mfr_pkg::C_WRP && !cs_hi;
  endsequence

  sequence seq_dummy_entry;
    s_reg.st != mfr_pkg::S_DUM && s_next.st == mfr_pkg::S_DUM;
  endsequence

  chk_dual_lanes: assert property ( // [RULE1]
    s_reg.st == mfr_pkg::S_DAT && s_reg.cmd == mfr_pkg::C_DO
    |-> s_reg.io_oe == 4'h0 || s_reg.io_oe == 4'h3)
    else $error("dual output drives wrong lines");

  chk_dummy_eight: assert property ( // [RULE2] [RULE5]
    seq_dummy_entry ##0 (s_reg.cmd == mfr_pkg::C_DO ||
                         s_reg.cmd == mfr_pkg::C_QO)
    |=> s_reg.dcnt == `MFR_DUM_OUT)
    else $error("output read dummy count not eight");

  chk_quad_gate: assert property ( // [RULE4] [RULE13]
    s_reg.st == mfr_pkg::S_OPC && s_next.st == mfr_pkg::S_ADR &&
    !quad_enable |=> s_reg.cmd == mfr_pkg::C_DO ||
    s_reg.cmd == mfr_pkg::C_DIO || s_reg.cmd == mfr_pkg::C_WRP)
    else $error("quad read accepted without quad enable");

  chk_addr_lanes: assert property ( // [RULE6] [RULE12]
    s_reg.st == mfr_pkg::S_ADR && rise && !cs_hi &&
    s_reg.cnt < 6'h14
    |=> s_reg.cnt == $past(s_reg.cnt) +
        {3'h0, addr_lanes(s_reg.cmd, quad_command_mode)})
    else $error("address lane count wrong");

  chk_cont_latch: assert property ( // [RULE8] [RULE9]
    seq_mode_done |=> s_reg.cont == (s_reg.sh[5:4] == `MFR_CONT_KEY))
    else $error("continuous mode not taken from mode bits");

  chk_skip_opcode: assert property ( // [RULE8] [RULE18]
    s_reg.st == mfr_pkg::S_IDLE && !cs_hi && s_reg.cont
    |=> s_reg.st == mfr_pkg::S_ADR)
    else $error("opcode expected in continuous mode");

  chk_qpi_dummy: assert property ( // [RULE16] [RULE17]
    seq_mode_done ##0 quad_command_mode &&
    dummy_count_field == 2'b00 |=> s_reg.st == mfr_pkg::S_DAT)
    else $error("default quad mode data not immediate");

  chk_spi_dummy: assert property ( // [RULE12]
    seq_dummy_entry ##0 !quad_command_mode &&
    s_reg.cmd == mfr_pkg::C_QIO |=> s_reg.dcnt == `MFR_DUM_QIO ##0
    (s_reg.st == mfr_pkg::S_DUM) [*2])
    else $error("quad io dummy count wrong");

  chk_wrap_bound: assert property ( // [RULE14] [RULE19]
    s_reg.st == mfr_pkg::S_DAT && wrap_on && s_next.st ==
    mfr_pkg::S_DAT && s_next.addr != s_reg.addr
    |=> s_reg.addr[23:6] == $past(s_reg.addr[23:6]))
    else $error("wrap left its section");

  chk_no_drive_idle: assert property ( // [RULE3]
    cs_hi |=> s_reg.io_oe == 4'h0)
    else $error("pins driven with chip select high");
endmodule : mfr_multi_io_fast_read

/* File: mfr_host_model.sv */
`timescale 1ns/1ps
module mfr_host_model (
  // system clock
  input wire logic clk,
  // flash link
  output logic sclk,
  output logic cs_n,
  output logic [3:0] h_out,
  output logic [3:0] h_oe,
  input wire logic [3:0] io
);
  // ---------------------------------
  // link clock idles low between frames
  // ---------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    h_out = 4'h0;
    h_oe = 4'h0;
  end
  // one period is 8 clk; sampled late in the high phase
  task automatic tick(input logic [3:0] oe, input logic [3:0] v,
    output logic [3:0] s);
    h_out <= v;
    h_oe <= oe;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (3) @(posedge clk);
    s = io;
    // let go in the high phase, ahead of any data-out falling edge
    h_oe <= 4'h0;
    @(posedge clk);
    sclk <= 1'b0;
  endtask : tick
  task automatic send(input logic [31:0] val, input int n, input int w);
    logic [3:0] s;
    logic [3:0] mk;
    mk = 4'((1 << w) - 1);
    for (int k = 0; k < n; k++) begin
      tick(mk, mk & 4'(val >> (w * (n - 1 - k))), s);
    end
  endtask : send
  // toggling junk, so ignored clocks are really ignored
  task automatic dummy(input int n, input logic [3:0] oe);
    logic [3:0] s;
    for (int k = 0; k < n; k++) begin
      tick(oe, k[0] ? 4'hA : 4'h5, s);
    end
  endtask : dummy
  task automatic recv(input int w, output logic [7:0] b);
    logic [3:0] s;
    b = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      tick(4'h0, 4'h0, s);
      b = (b << w) | 8'(s & 4'((1 << w) - 1));
    end
  endtask : recv
  // ---------------------------------
  // framing
  // ---------------------------------
  task automatic start;
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : start
  task automatic stop;
    h_oe <= 4'h0;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : stop
endmodule : mfr_host_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [7:0] op;
    logic [23:0] a;
    int aw;
    int dum;
    int dw;
  } mfr_row_t;
  logic clk, rst, quad_enable, quad_command_mode, sclk, cs_n;
  logic cont_mode_active;
  logic [1:0] dummy_count_field;
  logic [3:0] io_out, io_oe, h_out, h_oe, io_wire;
  logic [23:0] mem_addr;
  logic [7:0] mem_data;
  logic [2:0] wrap_setting_bits;
  int error_cnt, num_checks, cyc;
  mfr_row_t rows [5];
  // ---------------------------------
  // clock, board and instances
  // ---------------------------------
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // released lines float high on board pull-ups
  assign io_wire = (io_oe & io_out) | (~io_oe & ~h_oe)
    | (~io_oe & h_oe & h_out);
  assign mem_data = mem_addr[7:0] ^ 8'h5A;
  mfr_multi_io_fast_read u_mfr_multi_io_fast_read (.clk, .rst, .sclk,
    .cs_n, .io_in(io_wire), .io_out, .io_oe, .quad_enable,
    .quad_command_mode, .dummy_count_field, .mem_addr, .mem_data,
    .cont_mode_active, .wrap_setting_bits);
  mfr_host_model u_mfr_host_model (.clk, .sclk, .cs_n, .h_out, .h_oe,
    .io(io_wire));
  // ---------------------------------
  // checking
  // ---------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end
  // address, mode byte on multi-line reads, dummies, n checked bytes
  task automatic rd(input int aw, input logic [23:0] a,
    input logic [7:0] m, input int dum, input int dw, input int n,
    input int wl);
    logic [7:0] b;
    logic [23:0] ea;
    u_mfr_host_model.send(a, 24 / aw, aw);
    if (aw > 1) u_mfr_host_model.send(m, 8 / aw, aw);
    u_mfr_host_model.dummy(dum, aw == 1 ? 4'h1 : 4'h0);
    for (int i = 0; i < n; i++) begin
      ea = a + 24'(i);
      if (wl > 0) ea = (a & ~24'(wl - 1)) | (ea & 24'(wl - 1));
      u_mfr_host_model.recv(dw, b);
      check(b, ea[7:0] ^ 8'h5A);
    end
    check(io_oe, dw == 2 ? 4'h3 : 4'hF);
  endtask : rd
  task automatic frame(input logic [7:0] op, input int n, input int w);
    u_mfr_host_model.start();
    u_mfr_host_model.send(op, n, w);
  endtask : frame
  // ---------------------------------
  // sequence
  // ---------------------------------
  initial begin
    rst = 1'b1;
    quad_enable = 1'b1;
    quad_command_mode = 1'b0;
    dummy_count_field = 2'h0;
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    rows[0] = '{8'h3B, 24'h000123, 1, 8, 2};
    rows[1] = '{8'h6B, 24'h00FFFE, 1, 8, 4};
    rows[2] = '{8'hBB, 24'h123456, 2, 0, 2};
    rows[3] = '{8'hEB, 24'hABCDEF, 4, 4, 4};
    rows[4] = '{8'hE7, 24'h000010, 4, 2, 4};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check({io_oe, io_out, cont_mode_active}, 9'h000);
    check(mem_addr, 24'h000000);
    check(wrap_setting_bits, 3'b001);
    foreach (rows[r]) begin
      frame(rows[r].op, 8, 1);
      rd(rows[r].aw, rows[r].a, 8'h0F, rows[r].dum, rows[r].dw, 3, 0);
      u_mfr_host_model.stop();
      check(cont_mode_active, 1'b0);
    end
    quad_enable <= 1'b0;
    foreach (rows[r]) begin
      if (r == 1 || r > 2) begin
        frame(rows[r].op, 8, 1);
        u_mfr_host_model.dummy(34, 4'h0);
        check(io_oe, 4'h0);
        u_mfr_host_model.stop();
      end
    end
    quad_enable <= 1'b1;
    frame(8'hBB, 8, 1);
    rd(2, 24'h000300, 8'h20, 0, 2, 2, 0);
    u_mfr_host_model.stop();
    check(cont_mode_active, 1'b1);
    u_mfr_host_model.start();
    rd(2, 24'h000400, 8'h20, 0, 2, 2, 0);
    u_mfr_host_model.stop();
    frame(8'hFF, 8, 1);
    u_mfr_host_model.send(8'hFF, 8, 1);
    u_mfr_host_model.stop();
    check(cont_mode_active, 1'b0);
    frame(8'hEB, 8, 1);
    rd(4, 24'h000500, 8'hA5, 4, 4, 2, 0);
    u_mfr_host_model.stop();
    frame(8'hFF, 8, 1);
    u_mfr_host_model.stop();
    check(cont_mode_active, 1'b0);
    for (int k = 0; k < 4; k++) begin
      frame(8'h77, 8, 1);
      u_mfr_host_model.send(32'h0, 24, 1);
      u_mfr_host_model.send(k << 5, 8, 1);
      u_mfr_host_model.stop();
      check(wrap_setting_bits, {2'(k), 1'b0});
      frame(8'hEB, 8, 1);
      rd(4, 24'h000100 + 24'((8 << k) - 2), 8'h0F, 4, 4, 4, 8 << k);
      u_mfr_host_model.stop();
    end
    quad_command_mode <= 1'b1;
    dummy_count_field <= 2'h1;
    frame(8'hEB, 2, 4);
    rd(4, 24'h00013E, 8'h20, 2, 4, 4, 0);
    u_mfr_host_model.stop();
    check(cont_mode_active, 1'b1);
    dummy_count_field <= 2'h0;
    u_mfr_host_model.start();
    rd(4, 24'h000600, 8'h00, 0, 4, 2, 0);
    u_mfr_host_model.stop();
    check(cont_mode_active, 1'b0);
    quad_command_mode <= 1'b0;
    frame(8'h77, 8, 1);
    u_mfr_host_model.send(32'h0, 24, 1);
    u_mfr_host_model.send(8'h9F, 8, 1);
    u_mfr_host_model.stop();
    check(wrap_setting_bits, 3'b001);
    frame(8'h77, 8, 1);
    u_mfr_host_model.send(32'h0, 24, 1);
    u_mfr_host_model.send(8'h40, 8, 1);
    u_mfr_host_model.stop();
    check(wrap_setting_bits, 3'b100);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check(wrap_setting_bits, 3'b001);
    check(io_oe, 4'h0);
    test_done();
  end
endmodule : tb_top
